// >>> include/rtbo_pkg.sv
//Contract
//RULE1 - Four relay delays: 0 to 300 s, 0.1 s
//RULE2 - Rising timer input energizes relay after on-delay
//RULE3 - Falling timer input releases relay after off-delay
//RULE4 - Input reverting early abandons change, resets timing
//RULE5 - Delayed relay only when selector holds timer
//RULE6 - Brake codes drive output from brake logic
//RULE7 - Release needs current over both, run, no fault
//RULE8 - Brake reapplied by comparing speed with threshold
//RULE9 - Encoder vector mode: no braking on reversal
//RULE10 - Run/stop only from first input's run option
//RULE11 - Compare motor current with current threshold
//RULE12 - Compare motor torque with torque threshold
//RULE13 - Compare process variable with low and high
//RULE14 - Compare output frequency with frequency threshold
//RULE15 - Speed reference comparison uses final total value
//RULE16 - Reset: relays off, counts cleared, brake applied
//RULE17 - Hours threshold 0 to 6553, default 4320
`default_nettype none
package rtbo_pkg;
	// Timing base: one delay step is a tenth of a second
	localparam int RTBO_CLK_HZ = 40_000_000;
	localparam int RTBO_STEP_MS = 100;
	localparam int RTBO_STEP_CYCLES = RTBO_CLK_HZ / 1000 * RTBO_STEP_MS;
	localparam int RTBO_PRE_W = 22;

	// Setting ranges and reset values
	localparam logic [15:0] RTBO_DELAY_MAX = 16'h0bb8;
	localparam logic [11:0] RTBO_DELAY_RST = 12'h000;
	localparam logic [15:0] RTBO_HOURS_MAX = 16'h1999;
	localparam logic [15:0] RTBO_HOURS_RST = 16'h10e0;

	// Output function selector codes
	localparam logic [5:0] RTBO_FN_OFF = 6'h00;
	localparam logic [5:0] RTBO_FN_IS_GT_IX = 6'h01;
	localparam logic [5:0] RTBO_FN_IS_LT_IX = 6'h02;
	localparam logic [5:0] RTBO_FN_TQ_GT_TX = 6'h03;
	localparam logic [5:0] RTBO_FN_TQ_LT_TX = 6'h04;
	localparam logic [5:0] RTBO_FN_PV_GT_HI = 6'h05;
	localparam logic [5:0] RTBO_FN_PV_LT_LO = 6'h06;
	localparam logic [5:0] RTBO_FN_NT_GT_NX = 6'h07;
	localparam logic [5:0] RTBO_FN_N_GT_NX = 6'h08;
	localparam logic [5:0] RTBO_FN_F_GT_FX = 6'h09;
	localparam logic [5:0] RTBO_FN_H_GT_HX = 6'h0a;
	localparam logic [5:0] RTBO_FN_TIMER = 6'h1c;
	localparam logic [5:0] RTBO_FN_BRAKE_A = 6'h1e;
	localparam logic [5:0] RTBO_FN_BRAKE_B = 6'h1f;

	// Mode codes
	localparam logic [3:0] RTBO_MODE_VEC_ENC = 4'h4;
	localparam logic [3:0] RTBO_DI1_RUN_STOP = 4'h1;
	localparam int RTBO_NUM_DI = 6;

	// Register byte offsets
	localparam logic [7:0] RTBO_OFS_B_ON = 8'h00;
	localparam logic [7:0] RTBO_OFS_B_OFF = 8'h04;
	localparam logic [7:0] RTBO_OFS_C_ON = 8'h08;
	localparam logic [7:0] RTBO_OFS_C_OFF = 8'h0c;
	localparam logic [7:0] RTBO_OFS_FUNC = 8'h10;
	localparam logic [7:0] RTBO_OFS_INMODE = 8'h14;
	localparam logic [7:0] RTBO_OFS_CURRENT = 8'h18;
	localparam logic [7:0] RTBO_OFS_SPDTRQ = 8'h1c;
	localparam logic [7:0] RTBO_OFS_PROCESS = 8'h20;
	localparam logic [7:0] RTBO_OFS_FRQHRS = 8'h24;
	localparam logic [7:0] RTBO_OFS_STATUS = 8'h28;

	// Measurements from the drive core
	typedef struct packed {
		logic [15:0] current;
		logic [15:0] magnetizing;
		logic [15:0] torque;
		logic [15:0] process;
		logic signed [15:0] total_ref;
		logic signed [15:0] speed;
		logic [15:0] frequency;
		logic [15:0] hours;
	} rtbo_meas_t;

	// Register layouts
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} rtbo_pair_reg_t;

	typedef struct packed {
		logic [1:0] rsv3;
		logic [5:0] sel_d2;
		logic [1:0] rsv2;
		logic [5:0] sel_d1;
		logic [1:0] rsv1;
		logic [5:0] sel_c;
		logic [1:0] rsv0;
		logic [5:0] sel_b;
	} rtbo_func_reg_t;

	typedef struct packed {
		logic [15:0] rsv2;
		logic [3:0] di1_fn;
		logic [3:0] mode;
		logic rsv1;
		logic [2:0] tin_c;
		logic rsv0;
		logic [2:0] tin_b;
	} rtbo_inmode_reg_t;

	typedef struct packed {
		logic is_gt_ix;
		logic is_lt_ix;
		logic tq_gt_tx;
		logic tq_lt_tx;
		logic pv_gt_hi;
		logic pv_lt_lo;
		logic nt_gt_nx;
		logic n_gt_nx;
		logic f_gt_fx;
		logic h_gt_hx;
	} rtbo_flags_t;

	typedef struct packed {
		logic [16:0] rsv;
		logic brake;
		logic [1:0] dout;
		logic relay_c;
		logic relay_b;
		rtbo_flags_t flags;
	} rtbo_status_reg_t;

	// Module state
	typedef struct packed {
		logic [11:0] b_on;
		logic [11:0] b_off;
		logic [11:0] c_on;
		logic [11:0] c_off;
		rtbo_func_reg_t func;
		rtbo_inmode_reg_t inmode;
		rtbo_pair_reg_t current;
		rtbo_pair_reg_t spdtrq;
		rtbo_pair_reg_t process;
		rtbo_pair_reg_t frqhrs;
		logic [RTBO_PRE_W-1:0] pre;
		logic tick;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic relay_b;
		logic relay_c;
		logic [1:0] dout;
	} rtbo_main_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic relay;
	} rtbo_delay_t;

	typedef struct packed {
		logic released;
	} rtbo_brake_t;

	// Clamp a setting to its upper limit
	function automatic logic [15:0] rtbo_sat(input logic [15:0] v,
		input logic [15:0] m);
		rtbo_sat = (v > m) ? m : v;
	endfunction

	// Magnitude of a signed speed
	function automatic logic [15:0] rtbo_abs(input logic signed [15:0] v);
		rtbo_abs = v[15] ? 16'(-v) : 16'(v);
	endfunction
endpackage
`default_nettype wire

// >>> hw/rtbo_relay_delay.sv
`timescale 1ns/1ps
`default_nettype none
module rtbo_relay_delay
	import rtbo_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic active,
	input wire logic level,
	input wire logic tick,
	input wire logic [11:0] on_delay,
	input wire logic [11:0] off_delay,
	// Relay drive
	output logic relay
);
	rtbo_delay_t s;
	rtbo_delay_t next_s;
	logic [11:0] delay;

	// Pick the delay of the pending direction
	assign delay = level ? on_delay : off_delay;

	// Count whole steps; the first step may be short by up to one step
	always_comb begin
		next_s = s;
		if (!active) begin
			next_s.cnt = RTBO_DELAY_RST;
			next_s.relay = 1'b0;
		end else if (level == s.relay) begin
			next_s.cnt = RTBO_DELAY_RST; // [RULE4]
		end else if (s.cnt >= delay) begin
			next_s.relay = level; // [RULE2] [RULE3]
			next_s.cnt = RTBO_DELAY_RST;
		end else if (tick) begin
			next_s.cnt = s.cnt + 12'h001;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0; // [RULE16]
		end else begin
			s <= next_s;
		end
	end

	assign relay = s.relay;
endmodule // rtbo_relay_delay
`default_nettype wire

// >>> hw/rtbo_brake_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rtbo_brake_ctrl
	import rtbo_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Conditions
	input wire logic run,
	input wire logic fault,
	input wire logic encoder_mode,
	input wire logic [15:0] current,
	input wire logic [15:0] current_threshold,
	input wire logic [15:0] magnetizing,
	input wire logic [15:0] speed_mag,
	input wire logic [15:0] speed_threshold,
	// Result
	output logic released
);
	rtbo_brake_t s;
	rtbo_brake_t next_s;
	logic can_release;
	logic low_speed;

	// Release needs both current comparisons plus a clean run
	assign can_release = run && !fault && (current > current_threshold) &&
		(current > magnetizing); // [RULE7]
	assign low_speed = !(speed_mag > speed_threshold); // [RULE8]

	// With encoder feedback a zero crossing while running is a reversal
	always_comb begin
		next_s = s;
		if (!s.released) begin
			next_s.released = can_release;
		end else if (fault) begin
			next_s.released = 1'b0;
		end else if (low_speed && (!run || !encoder_mode)) begin
			next_s.released = 1'b0; // [RULE9]
		end
	end

	// State register; reset leaves the brake applied
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0; // [RULE16]
		end else begin
			s <= next_s;
		end
	end

	assign released = s.released;
endmodule // rtbo_brake_ctrl
`default_nettype wire

// >>> hw/rtbo_relay_timer_brake_output.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rtbo_relay_timer_brake_output
	import rtbo_pkg::*;
#(
	parameter int STEP_CYCLES = RTBO_STEP_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive inputs
	input wire logic [RTBO_NUM_DI-1:0] digital_inputs,
	input wire logic fault_active,
	input wire rtbo_meas_t meas,
	// Outputs
	output logic relay_b,
	output logic relay_c,
	output logic [1:0] digital_output_n,
	output logic brake_released
);
	rtbo_main_t s;
	rtbo_main_t next_s;
	rtbo_flags_t flags;
	rtbo_status_reg_t status;
	logic timer_b;
	logic timer_c;
	logic brake;
	logic run;
	logic level_b;
	logic level_c;
	logic [15:0] speed_mag;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	// Map a selector code onto its output level
	function automatic logic rtbo_out_fn(input logic [5:0] sel,
		input rtbo_flags_t f, input logic timer, input logic brk);
		logic v;
		v = 1'b0;
		unique case (sel)
			RTBO_FN_IS_GT_IX: v = f.is_gt_ix;
			RTBO_FN_IS_LT_IX: v = f.is_lt_ix;
			RTBO_FN_TQ_GT_TX: v = f.tq_gt_tx;
			RTBO_FN_TQ_LT_TX: v = f.tq_lt_tx;
			RTBO_FN_PV_GT_HI: v = f.pv_gt_hi;
			RTBO_FN_PV_LT_LO: v = f.pv_lt_lo;
			RTBO_FN_NT_GT_NX: v = f.nt_gt_nx;
			RTBO_FN_N_GT_NX: v = f.n_gt_nx;
			RTBO_FN_F_GT_FX: v = f.f_gt_fx;
			RTBO_FN_H_GT_HX: v = f.h_gt_hx;
			RTBO_FN_TIMER: v = timer; // [RULE5]
			RTBO_FN_BRAKE_A, RTBO_FN_BRAKE_B: v = brk; // [RULE6]
			default: v = 1'b0;
		endcase
		rtbo_out_fn = v;
	endfunction

	// Pick a timer input; an index past the last input reads low
	function automatic logic rtbo_pick(input logic [2:0] idx,
		input logic [RTBO_NUM_DI-1:0] di);
		rtbo_pick = (int'(idx) < RTBO_NUM_DI) ? di[idx] : 1'b0;
	endfunction

	// Threshold comparisons on the live measurements
	assign speed_mag = rtbo_abs(meas.speed);
	always_comb begin
		flags.is_gt_ix = meas.current > s.current.lo; // [RULE11]
		flags.is_lt_ix = meas.current < s.current.lo; // [RULE11]
		flags.tq_gt_tx = meas.torque > s.spdtrq.hi; // [RULE12]
		flags.tq_lt_tx = meas.torque < s.spdtrq.hi; // [RULE12]
		flags.pv_gt_hi = meas.process > s.process.hi; // [RULE13]
		flags.pv_lt_lo = meas.process < s.process.lo; // [RULE13]
		flags.nt_gt_nx = rtbo_abs(meas.total_ref) > s.spdtrq.lo; // [RULE15]
		flags.n_gt_nx = speed_mag > s.spdtrq.lo;
		flags.f_gt_fx = meas.frequency > s.frqhrs.lo; // [RULE14]
		flags.h_gt_hx = meas.hours > s.frqhrs.hi;
	end

	// Run comes only from the first input in its run/stop role
	assign run = (s.inmode.di1_fn == RTBO_DI1_RUN_STOP) &&
		digital_inputs[0]; // [RULE10]
	assign level_b = rtbo_pick(s.inmode.tin_b, digital_inputs);
	assign level_c = rtbo_pick(s.inmode.tin_c, digital_inputs);

	// Relay delay timers
	rtbo_relay_delay u_delay_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.active(s.func.sel_b == RTBO_FN_TIMER),
		.level(level_b),
		.tick(s.tick),
		.on_delay(s.b_on),
		.off_delay(s.b_off),
		.relay(timer_b)
	);

	rtbo_relay_delay u_delay_c (
		.mclk(mclk),
		.rst_n(rst_n),
		.active(s.func.sel_c == RTBO_FN_TIMER),
		.level(level_c),
		.tick(s.tick),
		.on_delay(s.c_on),
		.off_delay(s.c_off),
		.relay(timer_c)
	);

	// Brake sequencing
	rtbo_brake_ctrl u_brake (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(run),
		.fault(fault_active),
		.encoder_mode(s.inmode.mode == RTBO_MODE_VEC_ENC),
		.current(meas.current),
		.current_threshold(s.current.lo),
		.magnetizing(meas.magnetizing),
		.speed_mag(speed_mag),
		.speed_threshold(s.spdtrq.lo),
		.released(brake)
	);

	// Status word
	always_comb begin
		status = '0;
		status.flags = flags;
		status.relay_b = s.relay_b;
		status.relay_c = s.relay_c;
		status.dout = s.dout;
		status.brake = brake;
	end

	// Bus phases; the answer comes in the second access cycle
	assign rd_en = psel && penable && !s.pready;
	assign wr_en = psel && penable && s.pready && pwrite;
	assign addr_ok = (paddr <= RTBO_OFS_STATUS) && (paddr[1:0] == 2'h0);

	// Next state: prescaler, bus slave, settings and output mux
	always_comb begin
		next_s = s;
		// Step prescaler; the full count is too long to simulate cheaply
		if (s.pre == RTBO_PRE_W'(STEP_CYCLES - 1)) begin
			next_s.pre = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.pre = s.pre + RTBO_PRE_W'(1);
			next_s.tick = 1'b0;
		end
		next_s.pready = rd_en;
		next_s.pslverr = rd_en && !addr_ok;
		// Only reads load the read data, so it stands across writes
		if (rd_en && !pwrite) begin
			unique case (paddr)
				RTBO_OFS_B_ON: next_s.prdata = 32'(s.b_on);
				RTBO_OFS_B_OFF: next_s.prdata = 32'(s.b_off);
				RTBO_OFS_C_ON: next_s.prdata = 32'(s.c_on);
				RTBO_OFS_C_OFF: next_s.prdata = 32'(s.c_off);
				RTBO_OFS_FUNC: next_s.prdata = s.func;
				RTBO_OFS_INMODE: next_s.prdata = s.inmode;
				RTBO_OFS_CURRENT: next_s.prdata = s.current;
				RTBO_OFS_SPDTRQ: next_s.prdata = s.spdtrq;
				RTBO_OFS_PROCESS: next_s.prdata = s.process;
				RTBO_OFS_FRQHRS: next_s.prdata = s.frqhrs;
				RTBO_OFS_STATUS: next_s.prdata = status;
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
		// Writes land at the edge that completes the access phase
		if (wr_en) begin
			unique case (paddr)
				RTBO_OFS_B_ON:
					next_s.b_on = 12'(rtbo_sat(pwdata[15:0],
						RTBO_DELAY_MAX)); // [RULE1]
				RTBO_OFS_B_OFF:
					next_s.b_off = 12'(rtbo_sat(pwdata[15:0],
						RTBO_DELAY_MAX)); // [RULE1]
				RTBO_OFS_C_ON:
					next_s.c_on = 12'(rtbo_sat(pwdata[15:0],
						RTBO_DELAY_MAX)); // [RULE1]
				RTBO_OFS_C_OFF:
					next_s.c_off = 12'(rtbo_sat(pwdata[15:0],
						RTBO_DELAY_MAX)); // [RULE1]
				RTBO_OFS_FUNC: begin
					next_s.func = pwdata;
					next_s.func.rsv0 = '0;
					next_s.func.rsv1 = '0;
					next_s.func.rsv2 = '0;
					next_s.func.rsv3 = '0;
				end
				RTBO_OFS_INMODE: begin
					next_s.inmode = pwdata;
					next_s.inmode.rsv0 = '0;
					next_s.inmode.rsv1 = '0;
					next_s.inmode.rsv2 = '0;
				end
				RTBO_OFS_CURRENT: next_s.current = pwdata;
				RTBO_OFS_SPDTRQ: next_s.spdtrq = pwdata;
				RTBO_OFS_PROCESS: next_s.process = pwdata;
				RTBO_OFS_FRQHRS: begin
					next_s.frqhrs.lo = pwdata[15:0];
					next_s.frqhrs.hi = rtbo_sat(pwdata[31:16],
						RTBO_HOURS_MAX); // [RULE17]
				end
				// Status and unmapped places ignore writes
				default: next_s.pready = 1'b0;
			endcase
		end
		// Outputs are registered once more to keep them glitch free
		next_s.relay_b = rtbo_out_fn(s.func.sel_b, flags, timer_b, brake);
		next_s.relay_c = rtbo_out_fn(s.func.sel_c, flags, timer_c, brake);
		next_s.dout[0] = rtbo_out_fn(s.func.sel_d1, flags, 1'b0, brake);
		next_s.dout[1] = rtbo_out_fn(s.func.sel_d2, flags, 1'b0, brake);
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0; // [RULE16]
			s.b_on <= RTBO_DELAY_RST; // [RULE1]
			s.b_off <= RTBO_DELAY_RST;
			s.c_on <= RTBO_DELAY_RST;
			s.c_off <= RTBO_DELAY_RST;
			s.frqhrs.hi <= RTBO_HOURS_RST; // [RULE17]
		end else begin
			s <= next_s;
		end
	end

	// Ports straight from the state flops; brake flop lives in u_brake
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign relay_b = s.relay_b;
	assign relay_c = s.relay_c;
	assign digital_output_n = s.dout;
	assign brake_released = brake;
endmodule // rtbo_relay_timer_brake_output
`default_nettype wire

// >>> verif/rtbo_relay_timer_brake_output_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rtbo_relay_timer_brake_output_monitor
	import rtbo_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Drive side
	input wire logic [RTBO_NUM_DI-1:0] digital_inputs,
	input wire logic fault_active,
	input wire rtbo_meas_t meas,
	input wire logic relay_b,
	input wire logic relay_c,
	input wire logic [1:0] digital_output_n,
	input wire logic brake_released
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Two-cycle access phase, answer stands one cycle
	a_ready_two_cycle: assert property ($rose(penable) && psel
		|-> !pready ##1 pready ##1 !pready) else $error("bad pready");
	// Misaligned or unmapped places are refused, others never
	a_refuse_bad_addr: assert property (pready && (paddr[1:0] != 2'h0
		|| paddr > 8'h28) |-> pslverr) else $error("no refusal");
	a_refuse_good_addr: assert property (pready && pslverr
		|-> paddr[1:0] != 2'h0 || paddr > 8'h28) else $error("refused");
	a_refuse_no_data: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read gave data");
	// Read data stands until the next read is taken
	a_read_hold: assert property (!(psel && penable && !pwrite)
		|=> $stable(prdata)) else $error("read data moved");
	// Outputs leave reset idle
	a_reset_idle: assert property (
		$past(!rst_n) |-> !relay_b && !relay_c && !brake_released
		&& digital_output_n == 2'h0) else $error("not idle");
	// Release needs current above magnetizing, run and no fault
	a_release_cause: assert property (
		$rose(brake_released) |-> $past(meas.current > meas.magnetizing
		&& digital_inputs[0] && !fault_active)) else $error("release");
	// A standing fault holds the brake on
	a_fault_applies: assert property (
		fault_active [*2] |-> !brake_released) else $error("fault");
	// Main scenarios
	c_release: cover property ($rose(brake_released));
	c_relay_b: cover property ($fell(relay_b));
	c_refused: cover property (pready && pslverr);
endmodule // rtbo_relay_timer_brake_output_monitor
`default_nettype wire

// >>> verif/rtbo_field.sv
`timescale 1ns/1ps
`default_nettype none
module rtbo_field
	import rtbo_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Switch contacts to the digital inputs
	output logic [RTBO_NUM_DI-1:0] digital_inputs
);
	// Contacts rest open until the operator moves one
	initial digital_inputs = '0;
	// A contact moves just after an edge and then stays put
	task automatic flip(input int idx, input logic lvl);
		@(posedge mclk);
		digital_inputs[idx] <= lvl;
	endtask
endmodule // rtbo_field
`default_nettype wire

// >>> verif/rtbo_relay_timer_brake_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtbo_relay_timer_brake_output_tb
	import rtbo_pkg::*;
;
	localparam int S = 4;
	logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, fault_active = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	rtbo_meas_t meas = '0;
	logic pready, pslverr, e, relay_b, relay_c, brake_released;
	logic [RTBO_NUM_DI-1:0] di;
	logic [1:0] dout;
	wire logic [2:0] outs;
	int n_mismatch = 0, n_compared = 0, n;
	assign outs = {brake_released, relay_c, relay_b};

	// Short step so that delays fit the run
	rtbo_relay_timer_brake_output #(.STEP_CYCLES(S)) dut (
		.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.digital_inputs(di), .fault_active(fault_active), .meas(meas),
		.relay_b(relay_b), .relay_c(relay_c),
		.digital_output_n(dout), .brake_released(brake_released));
	rtbo_field u_field (.mclk(mclk), .digital_inputs(di));

	// 40 MHz clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask

	// Output s must reach lvl after lo to hi edges
	task automatic wt(input int s, input logic lvl, input int lo, hi);
		n = 0;
		while (outs[s] !== lvl && n < hi) begin
			@(posedge mclk);
			n++;
		end
		chk(n >= lo && outs[s] === lvl, 1'b1);
		if (outs[s] !== lvl)
			finish_test();
	endtask

	// Output s must hold lvl for k edges
	task automatic hold(input int s, input logic lvl, input int k);
		logic bad;
		bad = 1'b0;
		repeat (k) begin
			@(posedge mclk);
			bad |= outs[s] !== lvl;
		end
		chk(bad, 1'b0);
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(8'(4 * i), 32'h0);
			wr(8'(4 * i), 32'h0bb9);
			rd(8'(4 * i), 32'h0bb8);
		end
		rd(RTBO_OFS_FRQHRS, 32'h10e00000);
		wr(RTBO_OFS_FRQHRS, 32'h1a000000);
		rd(RTBO_OFS_FRQHRS, 32'h19990000);
		// Refusals: unmapped read, misaligned write; status write is quiet
		rd(8'h2c, 32'h0);
		chk(e, 1'b1);
		wr(8'h05, 32'h1);
		chk(e, 1'b1);
		wr(RTBO_OFS_STATUS, 32'hffffffff);
		chk(e, 1'b0);
		// Relay B on DI2 at 3/2 steps, relay C on DI3 at 0/1
		wr(RTBO_OFS_B_ON, 32'h3);
		wr(RTBO_OFS_B_OFF, 32'h2);
		wr(RTBO_OFS_C_ON, 32'h0);
		wr(RTBO_OFS_C_OFF, 32'h1);
		wr(RTBO_OFS_FUNC, 32'h1f1e1c1c);
		wr(RTBO_OFS_INMODE, 32'h00001021);
		u_field.flip(1, 1'b1);
		wt(0, 1'b1, 2 * S, 3 * S + 5);
		u_field.flip(2, 1'b1);
		wt(1, 1'b1, 1, 5);
		// Blips shorter than the delay are forgotten
		u_field.flip(1, 1'b0);
		u_field.flip(1, 1'b1);
		hold(0, 1'b1, 6 * S);
		u_field.flip(1, 1'b0);
		wt(0, 1'b0, S, 2 * S + 5);
		u_field.flip(1, 1'b1);
		repeat (S) @(posedge mclk);
		u_field.flip(1, 1'b0);
		hold(0, 1'b0, 6 * S);
		u_field.flip(2, 1'b0);
		wt(1, 1'b0, 1, S + 5);
		wr(RTBO_OFS_FUNC, 32'h1f1e1c00);
		u_field.flip(1, 1'b1);
		hold(0, 1'b0, 6 * S);
		// Brake: Ix 100, Nx 50, torque 50, magnetizing 80
		wr(RTBO_OFS_CURRENT, 32'h64);
		wr(RTBO_OFS_SPDTRQ, 32'h00320032);
		meas <= '{16'd90, 16'd80, 16'd0, 16'd0, 16'sd0, 16'sd200,
			16'd0, 16'd0};
		u_field.flip(0, 1'b1);
		hold(2, 1'b0, 20);
		meas.current <= 16'd120;
		wt(2, 1'b1, 1, 6);
		// Digital outputs follow the brake flop one edge later
		@(posedge mclk);
		chk(dout, 2'h3);
		fault_active <= 1'b1;
		wt(2, 1'b0, 1, 6);
		@(posedge mclk);
		fault_active <= 1'b0;
		wt(2, 1'b1, 1, 6);
		u_field.flip(0, 1'b0);
		hold(2, 1'b1, 20);
		meas.speed <= -16'sd50;
		wt(2, 1'b0, 1, 6);
		// Encoder vector mode rides through zero speed
		wr(RTBO_OFS_INMODE, 32'h00001421);
		u_field.flip(0, 1'b1);
		wt(2, 1'b1, 1, 6);
		meas.speed <= 16'sd0;
		meas.current <= 16'd90;
		hold(2, 1'b1, 20);
		wr(RTBO_OFS_INMODE, 32'h00001021);
		wt(2, 1'b0, 1, 8);
		wr(RTBO_OFS_INMODE, 32'h00002021);
		meas.current <= 16'd120;
		hold(2, 1'b0, 20);
		// Comparator flags just past and just short of each threshold
		wr(RTBO_OFS_PROCESS, 32'h0014000a);
		wr(RTBO_OFS_FRQHRS, 32'h1999003c);
		meas <= '{16'd120, 16'd80, 16'd40, 16'd25, -16'sd60, -16'sd30,
			16'd70, 16'd6554};
		apb(1'b0, RTBO_OFS_STATUS, 32'h0);
		chk(q[9:0], 10'h26b);
		meas <= '{16'd90, 16'd80, 16'd60, 16'd5, 16'sd50, -16'sd51,
			16'd60, 16'd6553};
		apb(1'b0, RTBO_OFS_STATUS, 32'h0);
		chk(q[9:0], 10'h194);
		// Reset mid-run drops the relay and returns settings to their reset values
		u_field.flip(2, 1'b1);
		wt(1, 1'b1, 1, 5);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(relay_c, 1'b0);
		rd(RTBO_OFS_B_ON, 32'h0);
		rd(RTBO_OFS_FRQHRS, 32'h10e00000);
		finish_test();
	end
endmodule // rtbo_relay_timer_brake_output_tb

bind rtbo_relay_timer_brake_output rtbo_relay_timer_brake_output_monitor
	u_mon (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.digital_inputs(digital_inputs), .fault_active(fault_active),
	.meas(meas), .relay_b(relay_b), .relay_c(relay_c),
	.digital_output_n(digital_output_n),
	.brake_released(brake_released));
`default_nettype wire
